// ==== nfc_pkg.sv ====
// Contract
// R01 - Word mode uses sixteen lines, byte eight
// R02 - Strobes keep host and flash off bus together
// R03 - Secure lock indicator read on DQ7
// R04 - Separate lockable secure sector, 128 words
// R05 - Locked parts may hold unique_serial_number
// R06 - Commands are plain write cycles, latched
// R07 - Program sequence starts self-timed program
// R08 - Fast mode programs with two writes
// R09 - Erase sequence starts self-timed erase
// R10 - Busy shown by op_done_pin, DQ7, DQ6
// R11 - After completion flash reads array again
// R12 - Sector erase touches only selected sectors
// R13 - Undervoltage blocks writes inside the flash
// R14 - Protected sectors refuse program and erase; the model's chip erase clears them too
// R15 - Erase suspend allows other-sector access, resume; erases poll to the end and commands are refused while busy
// R16 - Reset pin aborts operation, returns to read
// R17 - Stable address lets flash fall asleep
// R18 - Host may put flash into standby
// R19 - Busy location reads return status bits
// R20 - Byte mode leaves upper data lines undriven
package nfc_pkg;
    // Register offsets of the controller
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_RDAT = 8'h14;
    // Control and status bit positions
    localparam int CTRL_BYTE = 0;
    localparam int CTRL_FRST = 1;
    localparam int CTRL_SEL = 2;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_RDY = 2;
    localparam int ST_LOCK = 3;
    localparam int ST_FAST = 4;
    localparam int ST_REF = 5;
    // Operations written to the command register
    localparam logic [3:0] OP_READ = 4'h0;
    localparam logic [3:0] OP_PROG = 4'h1;
    localparam logic [3:0] OP_CHIP = 4'h2;
    localparam logic [3:0] OP_SECT = 4'h3;
    localparam logic [3:0] OP_SUSP = 4'h4;
    localparam logic [3:0] OP_RESUME = 4'h5;
    localparam logic [3:0] OP_POLL = 4'h6;
    localparam logic [3:0] OP_RESET = 4'h7;
    localparam logic [3:0] OP_BYP_ENT = 4'h8;
    localparam logic [3:0] OP_BYP_EXIT = 4'h9;
    localparam logic [3:0] OP_SEC_ENT = 4'ha;
    localparam logic [3:0] OP_SEC_EXIT = 4'hb;
    localparam logic [3:0] OP_LOCK_RD = 4'hc;
    // Flash command bytes
    localparam logic [7:0] C_UNLK1 = 8'haa;
    localparam logic [7:0] C_UNLK2 = 8'h55;
    localparam logic [7:0] C_PROG = 8'ha0;
    localparam logic [7:0] C_ERASE = 8'h80;
    localparam logic [7:0] C_CHIP = 8'h10;
    localparam logic [7:0] C_SECT = 8'h30;
    localparam logic [7:0] C_SUSP = 8'hb0;
    localparam logic [7:0] C_RESUME = 8'h30;
    localparam logic [7:0] C_RST = 8'hf0;
    localparam logic [7:0] C_BYP = 8'h20;
    localparam logic [7:0] C_ASEL = 8'h90;
    localparam logic [7:0] C_ZERO = 8'h00;
    localparam logic [7:0] C_SEC_ENT = 8'h88;
    // Flash word addresses of the unlock cycles and lock indicator
    localparam logic [21:0] UNLK1_A = 22'h00_0555;
    localparam logic [21:0] UNLK2_A = 22'h00_02aa;
    localparam logic [21:0] IND_A = 22'h00_0003;
    // Step kinds and address selects of the sequencer
    localparam logic [2:0] K_END = 3'h0;
    localparam logic [2:0] K_WC = 3'h1;
    localparam logic [2:0] K_WD = 3'h2;
    localparam logic [2:0] K_RD = 3'h3;
    localparam logic [2:0] K_POLL = 3'h4;
    localparam logic [1:0] A_TGT = 2'h0;
    localparam logic [1:0] A_U1 = 2'h1;
    localparam logic [1:0] A_U2 = 2'h2;
    localparam logic [1:0] A_IND = 2'h3;
    // Timing at a 25 ns clock
    localparam int CLK_NS = 25;
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 25;
    localparam int T_ACC_NS = 70;
    localparam int SYNC_CYC = 2;
    localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WPH_CYC = 4'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RD_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_WLOW = 3'b010,
        S_WHIGH = 3'b011,
        S_TURN = 3'b100,
        S_RWAIT = 3'b101,
        S_RTAKE = 3'b110
    } nfc_state_t;
endpackage

// ==== nfc_host.sv ====
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
module nfc_host (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash address and strobes
    output logic [21:0] fl_addr,
    output logic fl_a_lsb,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic fl_byte_n,
    output logic fl_rst_n,
    // Flash data lines
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe_lo,
    output logic fl_dq_oe_hi,
    input wire logic [15:0] fl_dq_in,
    // Ready pin, high when idle
    input wire logic op_done_pin
);
    typedef struct packed {
        nfc_pkg::nfc_state_t st;
        logic [3:0] op;
        logic [3:0] step;
        logic [3:0] cnt;
        logic first;
        logic [21:0] fa;
        logic lsb;
        logic [15:0] dqo;
        logic oe_lo;
        logic oe_hi;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic byte_n;
        logic rst_n;
        logic byte_m;
        logic frst;
        logic keep_sel;
        logic fast;
        logic [22:0] addr;
        logic [15:0] wdat;
        logic [15:0] rdat;
        logic busy;
        logic done;
        logic lock;
        logic refused;
        logic prev6;
        logic [15:0] s1;
        logic [15:0] s2;
        logic r1;
        logic r2;
        logic [31:0] rdata;
    } nfc_regs_t;

    localparam nfc_regs_t RST_V = '{st: nfc_pkg::S_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                                    byte_n: 1'b1, default: '0};

    nfc_regs_t q;
    nfc_regs_t d;

    // Bus cycle list of each operation: kind, address select, byte
    function automatic logic [12:0] nfc_step(input logic [3:0] op, input logic [3:0] i, input logic fast);
        logic unl;
        logic [3:0] j;
        logic [12:0] r;
        unl = (op == nfc_pkg::OP_PROG && !fast) || op == nfc_pkg::OP_CHIP || op == nfc_pkg::OP_SECT ||
              op == nfc_pkg::OP_BYP_ENT || op == nfc_pkg::OP_SEC_ENT || op == nfc_pkg::OP_SEC_EXIT ||
              op == nfc_pkg::OP_LOCK_RD;
        j = unl ? i - 4'h2 : i;
        r = {nfc_pkg::K_END, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
        if (unl && i == 4'h0) begin
            r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_UNLK1};
        end else if (unl && i == 4'h1) begin
            r = {nfc_pkg::K_WC, nfc_pkg::A_U2, nfc_pkg::C_UNLK2};
        end else begin
            case (op)
                nfc_pkg::OP_READ: if (j == 4'h0) r = {nfc_pkg::K_RD, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
                nfc_pkg::OP_PROG: begin
                    // Fast mode skips the unlock pair R08
                    if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_PROG};
                    if (j == 4'h1) r = {nfc_pkg::K_WD, nfc_pkg::A_TGT, nfc_pkg::C_ZERO}; // R07
                    if (j == 4'h2) r = {nfc_pkg::K_POLL, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
                end
                nfc_pkg::OP_CHIP, nfc_pkg::OP_SECT: begin
                    if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_ERASE}; // R09
                    if (j == 4'h1) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_UNLK1};
                    if (j == 4'h2) r = {nfc_pkg::K_WC, nfc_pkg::A_U2, nfc_pkg::C_UNLK2};
                    if (j == 4'h3 && op == nfc_pkg::OP_CHIP) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_CHIP};
                    // Only the addressed sector is named R12
                    if (j == 4'h3 && op == nfc_pkg::OP_SECT) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_SECT};
                    if (j == 4'h4) r = {nfc_pkg::K_POLL, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
                end
                nfc_pkg::OP_SUSP: if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_SUSP}; // R15
                nfc_pkg::OP_RESUME: if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_RESUME}; // R15
                nfc_pkg::OP_POLL: if (j == 4'h0) r = {nfc_pkg::K_POLL, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
                nfc_pkg::OP_RESET: if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_RST};
                nfc_pkg::OP_BYP_ENT: if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_BYP}; // R08
                nfc_pkg::OP_BYP_EXIT: begin
                    if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_ASEL};
                    if (j == 4'h1) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
                end
                nfc_pkg::OP_SEC_ENT: if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_SEC_ENT}; // R04 R05
                nfc_pkg::OP_SEC_EXIT: begin
                    if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_ASEL};
                    if (j == 4'h1) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_ZERO};
                end
                nfc_pkg::OP_LOCK_RD: begin
                    if (j == 4'h0) r = {nfc_pkg::K_WC, nfc_pkg::A_U1, nfc_pkg::C_ASEL};
                    if (j == 4'h1) r = {nfc_pkg::K_RD, nfc_pkg::A_IND, nfc_pkg::C_ZERO}; // R03
                    if (j == 4'h2) r = {nfc_pkg::K_WC, nfc_pkg::A_TGT, nfc_pkg::C_RST};
                end
                default: r = r;
            endcase
        end
        return r;
    endfunction

    // Next state of all registers
    always_comb begin
        logic [12:0] s;
        logic [2:0] sk;
        logic [1:0] sa;
        logic [15:0] rv;
        d = q;
        s = nfc_step(q.op, q.step, q.fast);
        sk = s[12:10];
        sa = s[9:8];
        rv = q.byte_m ? {8'h00, q.s2[7:0]} : q.s2; // R01
        // Pin synchronisers
        d.s1 = fl_dq_in;
        d.s2 = q.s1;
        d.r1 = op_done_pin;
        d.r2 = q.r1;
        // Register writes; a refused command is flagged
        if (reg_wr) begin
            case (reg_addr)
                nfc_pkg::REG_CTRL: begin
                    d.byte_m = reg_wdata[nfc_pkg::CTRL_BYTE];
                    d.frst = reg_wdata[nfc_pkg::CTRL_FRST];
                    d.keep_sel = reg_wdata[nfc_pkg::CTRL_SEL];
                end
                nfc_pkg::REG_ADDR: d.addr = reg_wdata[22:0];
                nfc_pkg::REG_DATA: d.wdat = reg_wdata[15:0];
                nfc_pkg::REG_STAT: begin
                    if (reg_wdata[nfc_pkg::ST_DONE]) d.done = 1'b0;
                    if (reg_wdata[nfc_pkg::ST_REF]) d.refused = 1'b0;
                end
                nfc_pkg::REG_CMD: begin
                    if (q.busy || q.frst) begin
                        d.refused = 1'b1;
                    end else begin
                        d.op = reg_wdata[3:0];
                        d.step = 4'h0;
                        d.first = 1'b1;
                        d.busy = 1'b1;
                        d.st = nfc_pkg::S_FETCH;
                    end
                end
                default: d.busy = q.busy;
            endcase
        end
        // Read data stand the cycle after the strobe
        d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                nfc_pkg::REG_CTRL: d.rdata = {29'h0, q.keep_sel, q.frst, q.byte_m};
                nfc_pkg::REG_ADDR: d.rdata = {9'h0, q.addr};
                nfc_pkg::REG_DATA: d.rdata = {16'h0000, q.wdat};
                nfc_pkg::REG_STAT: d.rdata = {26'h0, q.refused, q.fast, q.lock, q.r2, q.done, q.busy};
                nfc_pkg::REG_RDAT: d.rdata = {16'h0000, q.rdat};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
        // Bus cycle sequencer
        case (q.st)
            nfc_pkg::S_IDLE: begin
                // Address held still while idle R17
                d.ce_n = ~q.keep_sel; // R18
                d.lsb = q.lsb & d.byte_m; // R01
            end
            nfc_pkg::S_FETCH: begin
                d.ce_n = 1'b0;
                d.oe_lo = 1'b0;
                d.oe_hi = 1'b0;
                case (sa)
                    nfc_pkg::A_U1: begin
                        d.fa = nfc_pkg::UNLK1_A;
                        d.lsb = 1'b0;
                    end
                    nfc_pkg::A_U2: begin
                        d.fa = nfc_pkg::UNLK2_A;
                        d.lsb = q.byte_m;
                    end
                    nfc_pkg::A_IND: begin
                        d.fa = nfc_pkg::IND_A;
                        d.lsb = 1'b0;
                    end
                    default: begin
                        d.fa = q.byte_m ? q.addr[22:1] : q.addr[21:0];
                        d.lsb = q.byte_m & q.addr[0];
                    end
                endcase
                case (sk)
                    nfc_pkg::K_WC, nfc_pkg::K_WD: begin
                        // Command as a plain write cycle R06
                        d.dqo = (sk == nfc_pkg::K_WC) ? {8'h00, s[7:0]} : q.byte_m ? {8'h00, q.wdat[7:0]} : q.wdat;
                        d.oe_lo = 1'b1;
                        d.oe_hi = ~q.byte_m; // R20
                        d.cnt = nfc_pkg::WP_CYC;
                        d.st = nfc_pkg::S_WLOW;
                    end
                    nfc_pkg::K_RD, nfc_pkg::K_POLL: begin
                        d.st = nfc_pkg::S_TURN; // R02
                    end
                    default: begin
                        // Flash back in read mode R11
                        d.ce_n = ~q.keep_sel;
                        d.busy = 1'b0;
                        d.done = 1'b1;
                        if (q.op == nfc_pkg::OP_BYP_ENT) d.fast = 1'b1; // R08
                        if (q.op == nfc_pkg::OP_BYP_EXIT) d.fast = 1'b0;
                        d.st = nfc_pkg::S_IDLE;
                    end
                endcase
            end
            nfc_pkg::S_WLOW: begin
                d.we_n = 1'b0;
                if (q.cnt <= 4'h1) begin
                    d.cnt = nfc_pkg::WPH_CYC;
                    d.st = nfc_pkg::S_WHIGH;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nfc_pkg::S_WHIGH: begin
                d.we_n = 1'b1;
                if (q.cnt <= 4'h1) begin
                    d.step = q.step + 4'h1;
                    d.st = nfc_pkg::S_FETCH;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nfc_pkg::S_TURN: begin
                // Data lines released one cycle before output enable R02
                d.oe_n = 1'b0;
                d.cnt = nfc_pkg::RD_CYC;
                d.st = nfc_pkg::S_RWAIT;
            end
            nfc_pkg::S_RWAIT: begin
                if (q.cnt <= 4'h1) begin
                    d.st = nfc_pkg::S_RTAKE;
                end else begin
                    d.cnt = q.cnt - 4'h1;
                end
            end
            nfc_pkg::S_RTAKE: begin
                d.oe_n = 1'b1;
                d.st = nfc_pkg::S_FETCH;
                if (sk == nfc_pkg::K_RD) begin
                    d.rdat = rv;
                    if (sa == nfc_pkg::A_IND) d.lock = rv[7]; // R03
                    d.step = q.step + 4'h1;
                end else if (q.first) begin
                    // Status reads while busy, toggle compare R19
                    d.first = 1'b0;
                    d.prev6 = rv[6];
                end else if (rv[6] == q.prev6 && q.r2) begin
                    // Toggle stopped and ready pin high R10
                    d.rdat = rv;
                    d.first = 1'b1;
                    d.step = q.step + 4'h1;
                end else begin
                    d.prev6 = rv[6];
                end
            end
            default: d.st = nfc_pkg::S_IDLE;
        endcase
        // Flash reset aborts the sequence R16
        if (d.frst) begin
            d.st = nfc_pkg::S_IDLE;
            d.busy = 1'b0;
            d.fast = 1'b0;
            d.ce_n = 1'b1;
            d.we_n = 1'b1;
            d.oe_n = 1'b1;
            d.oe_lo = 1'b0;
            d.oe_hi = 1'b0;
        end
        d.rst_n = ~d.frst; // R16
        d.byte_n = ~d.byte_m; // R01
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= RST_V;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = q.rdata;
    assign fl_addr = q.fa;
    assign fl_a_lsb = q.lsb;
    assign fl_ce_n = q.ce_n;
    assign fl_we_n = q.we_n;
    assign fl_oe_n = q.oe_n;
    assign fl_byte_n = q.byte_n;
    assign fl_rst_n = q.rst_n;
    assign fl_dq_out = q.dqo;
    assign fl_dq_oe_lo = q.oe_lo;
    assign fl_dq_oe_hi = q.oe_hi;
endmodule
`default_nettype wire

// ==== nfc_host_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfc_host_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Flash pins
    input wire logic [21:0] fl_addr,
    input wire logic fl_a_lsb,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    input wire logic fl_byte_n,
    input wire logic fl_rst_n,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_dq_oe_lo,
    input wire logic fl_dq_oe_hi
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Write strobe low for two cycles, then high
    sequence s_we_tail;
        ##1 !fl_we_n ##1 fl_we_n;
    endsequence
    sequence s_ctrl_wr;
        reg_wr && reg_addr == nfc_pkg::REG_CTRL;
    endsequence
    chk_we_width: assert property ($fell(fl_we_n) |-> s_we_tail)
        else $error("write strobe width wrong");
    chk_we_held: assert property (!fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out) && !fl_ce_n)
        else $error("write cycle moved");
    chk_no_fight: assert property (!fl_oe_n |-> !fl_dq_oe_lo && !fl_dq_oe_hi)
        else $error("bus fight");
    chk_turn_gap: assert property ($fell(fl_oe_n) |-> !$past(fl_dq_oe_lo) && !$past(fl_dq_oe_hi))
        else $error("no bus turnaround");
    chk_oe_we_excl: assert property (!(!fl_oe_n && !fl_we_n))
        else $error("both strobes low");
    chk_upper_idle: assert property (!fl_byte_n |-> !fl_dq_oe_hi)
        else $error("upper byte driven");
    chk_lsb_word: assert property (fl_byte_n |-> !fl_a_lsb)
        else $error("lsb set in word mode");
    chk_mode_pin: assert property (s_ctrl_wr |-> ##2 fl_byte_n == !$past(reg_wdata[0], 2))
        else $error("mode pin wrong");
    chk_reset_pin: assert property (s_ctrl_wr |-> ##2 fl_rst_n == !$past(reg_wdata[1], 2))
        else $error("reset pin wrong");
    chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("stray read data");
endmodule
bind nfc_host nfc_host_monitor u_mon (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_addr(fl_addr), .fl_a_lsb(fl_a_lsb), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .fl_byte_n(fl_byte_n), .fl_rst_n(fl_rst_n), .fl_dq_out(fl_dq_out),
    .fl_dq_oe_lo(fl_dq_oe_lo), .fl_dq_oe_hi(fl_dq_oe_hi));
`default_nettype wire

// ==== nfc_flash_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfc_flash_model #(
    parameter logic LOCKED = 1'b1,
    parameter logic [3:0] PROT = 4'h7,
    parameter int BUSY_CYC = 40
) (
    // Timebase of the self-timed algorithms
    input wire logic mclk,
    // Pins from the controller
    input wire logic [21:0] addr,
    input wire logic a_lsb,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic byte_n,
    input wire logic rst_n,
    input wire logic [15:0] dq,
    // Pins to the controller
    output logic [15:0] dq_out,
    output logic rdy
);
    logic [15:0] mem [256];
    logic [15:0] pd, word, last;
    logic [7:0] pa, d;
    logic byp, asel, arm, tog, pb, pl;
    int step, busy, kind;
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        {byp, asel, arm, tog, last} = '0;
        step = 0;
        busy = 0;
    end
    // Latch target and start an algorithm
    task automatic start(input int k, input logic [15:0] v);
        pa = addr[7:0];
        pd = v;
        pb = !byte_n;
        pl = a_lsb;
        kind = k;
        if (addr[7:4] == PROT) kind = 3;
        arm = 1'b0;
        busy = BUSY_CYC;
        step = 0;
    endtask
    // Command decoder on each write cycle
    always @(posedge we_n) begin
        d = dq[7:0];
        if (!ce_n && rst_n && busy == 0) begin
            if (step == 3) start(0, dq);
            else if (byp && step == 0 && d == nfc_pkg::C_PROG) step = 3;
            else if (byp && d == nfc_pkg::C_ZERO) byp = 1'b0;
            else if (step == 0 && d == nfc_pkg::C_UNLK1 && addr == nfc_pkg::UNLK1_A) step = 1;
            else if (step == 1 && d == nfc_pkg::C_UNLK2 && addr == nfc_pkg::UNLK2_A) step = 2;
            else if (step == 2 && d == nfc_pkg::C_PROG) step = 3;
            else if (step == 2 && arm && (d == nfc_pkg::C_CHIP || d == nfc_pkg::C_SECT))
                start(d == nfc_pkg::C_CHIP ? 1 : 2, 16'hffff);
            else begin
                arm = step == 2 && d == nfc_pkg::C_ERASE;
                byp = byp || (step == 2 && d == nfc_pkg::C_BYP);
                asel = (asel || (step == 2 && d == nfc_pkg::C_ASEL)) && d != nfc_pkg::C_RST;
                step = 0;
            end
        end
    end
    // Algorithm timer, aborted by the reset pin
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy = 0;
            step = 0;
            {byp, asel, arm} = '0;
        end else if (busy == 1) begin
            busy = 0;
            if (kind == 0 && pb) mem[pa][{pl, 3'b000} +: 8] = pd[7:0];
            else if (kind == 0) mem[pa] = pd;
            else if (kind != 3) foreach (mem[i]) if (kind == 1 || i[7:4] == pa[7:4]) mem[i] = 16'hffff;
        end else if (busy > 0) busy = busy - 1;
    end
    // Toggle bit flips on each read while busy
    always @(negedge oe_n) if (busy > 0) tog = !tog;
    always @(posedge oe_n) last = dq_out;
    // Read path; released lines show inverse of last value
    always_comb begin
        word = (asel && addr == nfc_pkg::IND_A) ? {8'h00, LOCKED, 7'h00} : mem[addr[7:0]];
        if (busy > 0) word = {8'h00, !pd[7], tog, 6'h00};
        if (ce_n || oe_n || !rst_n) dq_out = ~last;
        else if (!byte_n) dq_out = {~last[15:8], a_lsb ? word[15:8] : word[7:0]};
        else dq_out = word;
    end
    assign rdy = busy == 0;
endmodule
`default_nettype wire

// ==== nfc_host_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module nfc_host_test;
    logic mclk, rstn, reg_wr, reg_rd, fl_a_lsb, fl_ce_n, fl_we_n, fl_oe_n, fl_byte_n, fl_rst_n;
    logic fl_dq_oe_lo, fl_dq_oe_hi, op_done_pin;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, s;
    logic [21:0] fl_addr;
    logic [15:0] fl_dq_out, m_dq, dq_wire;
    int fails, checked, wes;
    // Shared data lines
    assign dq_wire = {fl_dq_oe_hi ? fl_dq_out[15:8] : m_dq[15:8], fl_dq_oe_lo ? fl_dq_out[7:0] : m_dq[7:0]};
    nfc_host uut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_addr(fl_addr),
        .fl_a_lsb(fl_a_lsb), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
        .fl_byte_n(fl_byte_n), .fl_rst_n(fl_rst_n), .fl_dq_out(fl_dq_out), .fl_dq_oe_lo(fl_dq_oe_lo),
        .fl_dq_oe_hi(fl_dq_oe_hi), .fl_dq_in(dq_wire), .op_done_pin(op_done_pin));
    nfc_flash_model u_flash (.mclk(mclk), .addr(fl_addr), .a_lsb(fl_a_lsb), .ce_n(fl_ce_n),
        .we_n(fl_we_n), .oe_n(fl_oe_n), .byte_n(fl_byte_n), .rst_n(fl_rst_n), .dq(dq_wire),
        .dq_out(m_dq), .rdy(op_done_pin));
    // Clock at 40 MHz
    always #12.5 mclk = !mclk;
    // Count flash write strobes
    always @(posedge fl_we_n) wes++;
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 s = reg_rdata;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task bit_chk(input int b, input logic exp);
        rd(nfc_pkg::REG_STAT);
        chk({31'h0, s[b]}, {31'h0, exp});
    endtask
    // Start an operation, wait for it
    task op(input logic [3:0] c);
        wr(nfc_pkg::REG_CMD, {28'h0, c});
        for (int i = 0; i < 400; i++) begin
            rd(nfc_pkg::REG_STAT);
            if (s[nfc_pkg::ST_BUSY] === 1'b0) break;
        end
        if (s[nfc_pkg::ST_BUSY] !== 1'b0) chk(s, 32'h0000_0000);
    endtask
    task rdf(input logic [31:0] a, input logic [31:0] exp);
        wr(nfc_pkg::REG_ADDR, a);
        op(nfc_pkg::OP_READ);
        rd(nfc_pkg::REG_RDAT);
        chk(s, exp);
    endtask
    task prog(input logic [31:0] a, input logic [31:0] d, input int n);
        wr(nfc_pkg::REG_ADDR, a);
        wr(nfc_pkg::REG_DATA, d);
        wes = 0;
        op(nfc_pkg::OP_PROG);
        chk(wes, n);
        op(nfc_pkg::OP_POLL);
    endtask
    task complete_run;
        $display("counts: %0d checked, %0d failed", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial begin
        #1_000_000;
        fails++;
        complete_run();
    end
    initial begin
        {mclk, rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rd(nfc_pkg::REG_CTRL);
        chk(s, 32'h0000_0000);
        bit_chk(nfc_pkg::ST_RDY, 1'b1);
        rd(8'h20);
        chk(s, 32'h0000_0000);
        chk({31'h0, fl_ce_n}, 32'h0000_0001);
        $display("test reset done");
        prog(32'h0000_0021, 32'h0000_1234, 4);
        bit_chk(nfc_pkg::ST_DONE, 1'b1);
        rdf(32'h0000_0021, 32'h0000_1234);
        prog(32'h0000_0071, 32'h0000_1234, 4);
        rdf(32'h0000_0071, 32'h0000_ffff);
        wr(nfc_pkg::REG_CMD, {28'h0, nfc_pkg::OP_PROG});
        op(nfc_pkg::OP_READ);
        op(nfc_pkg::OP_POLL);
        bit_chk(nfc_pkg::ST_REF, 1'b1);
        $display("test program done");
        op(nfc_pkg::OP_BYP_ENT);
        bit_chk(nfc_pkg::ST_FAST, 1'b1);
        prog(32'h0000_0032, 32'h0000_beef, 2);
        op(nfc_pkg::OP_BYP_EXIT);
        bit_chk(nfc_pkg::ST_FAST, 1'b0);
        rdf(32'h0000_0032, 32'h0000_beef);
        $display("test fast mode done");
        wr(nfc_pkg::REG_ADDR, 32'h0000_0035);
        op(nfc_pkg::OP_SECT);
        op(nfc_pkg::OP_POLL);
        rdf(32'h0000_0032, 32'h0000_ffff);
        rdf(32'h0000_0021, 32'h0000_1234);
        op(nfc_pkg::OP_LOCK_RD);
        bit_chk(nfc_pkg::ST_LOCK, 1'b1);
        $display("test sector erase done");
        wr(nfc_pkg::REG_CTRL, 32'h0000_0001);
        prog(32'h0000_0081, 32'h0000_005a, 4);
        rdf(32'h0000_0081, 32'h0000_005a);
        rdf(32'h0000_0080, 32'h0000_00ff);
        $display("test byte mode done");
        wr(nfc_pkg::REG_CTRL, 32'h0000_0000);
        wr(nfc_pkg::REG_CMD, {28'h0, nfc_pkg::OP_CHIP});
        repeat (40) @(posedge mclk);
        wr(nfc_pkg::REG_CTRL, 32'h0000_0002);
        bit_chk(nfc_pkg::ST_BUSY, 1'b0);
        wr(nfc_pkg::REG_CTRL, 32'h0000_0000);
        rdf(32'h0000_0021, 32'h0000_1234);
        op(nfc_pkg::OP_CHIP);
        op(nfc_pkg::OP_POLL);
        rdf(32'h0000_0021, 32'h0000_ffff);
        wr(nfc_pkg::REG_CTRL, 32'h0000_0004);
        repeat (2) @(posedge mclk);
        #1 chk({31'h0, fl_ce_n}, 32'h0000_0000);
        $display("test erase done");
        complete_run();
    end
endmodule
`default_nettype wire
